// ---- design/mcsf_pkg.sv ----
// package: constants and carriers for the machine check stack frame unit
package mcsf_pkg;
  // frame layout: longword index from the stack pointer
  localparam int MCSF_WORDS = 9;
  localparam logic [31:0] MCSF_BYTE_COUNT = 32'h0000_0018;
  localparam logic [31:0] MCSF_FRAME_BYTES = 32'h0000_0024;
  localparam logic [3:0] MCSF_IDX_COUNT = 4'h0;
  localparam logic [3:0] MCSF_IDX_CODE = 4'h1;
  localparam logic [3:0] MCSF_IDX_INTSTATE = 4'h2;
  localparam logic [3:0] MCSF_IDX_MICROCODE_SAVED_PC = 4'h3;
  localparam logic [3:0] MCSF_IDX_ADDRLATCH = 4'h4;
  localparam logic [3:0] MCSF_IDX_SHIFTLATCH = 4'h5;
  localparam logic [3:0] MCSF_IDX_OPWORD = 4'h6;
  localparam logic [3:0] MCSF_IDX_PC = 4'h7;
  localparam logic [3:0] MCSF_IDX_PSL = 4'h8;
  // field positions
  localparam int MCSF_TRAP_LSB = 29;
  localparam int MCSF_CODE_LSB = 16;
  localparam int MCSF_RIDX_LSB = 28;
  localparam int MCSF_MODE_LSB = 24;
  localparam int MCSF_OPC_LSB = 16;
  localparam int MCSF_RESTART_BIT = 7;
  localparam int MCSF_PSL_MODE_LSB = 24;
  // reason codes
  localparam logic [7:0] MCSF_CODE_MMSTAT = 8'h01;
  localparam logic [7:0] MCSF_CODE_INTID = 8'h02;
  localparam logic [7:0] MCSF_CODE_DISPATCH = 8'h03;
  localparam logic [7:0] MCSF_CODE_STRMOVE = 8'h04;
  localparam logic [7:0] MCSF_CODE_ASYNC = 8'h05;
  localparam logic [7:0] MCSF_CODE_SYNC = 8'h06;
  localparam logic [7:0] MCSF_HALT_DOUBLE = 8'h12;
  // register map of this unit, byte addresses
  localparam logic [7:0] MCSF_ADR_ACK = 8'h00;
  localparam logic [7:0] MCSF_ADR_STATUS = 8'h04;
  localparam logic [7:0] MCSF_ADR_SP = 8'h08;
  localparam logic [7:0] MCSF_ADR_LASTCODE = 8'h0C;
  localparam logic [31:0] MCSF_SP_RESET = 32'h0000_1000;
  // machine check sources, one bit each, code = index + 1
  localparam int MCSF_NSRC = 6;
  // captured processor state at the fault
  typedef struct packed {
    logic [2:0] trap_level;
    logic [7:0] proc_number;
    logic [31:0] int_state;
    logic [31:0] saved_pc;
    logic [31:0] addr_latch;
    logic [31:0] shift_latch;
    logic [3:0] reg_index;
    logic [7:0] opcode;
    logic clean;
    logic [31:0] pc;
    logic [31:0] processor_status_longword;
  } mcsf_state_s;
  // one stack write
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } mcsf_wr_s;
  typedef enum logic [1:0] {
    MCSF_IDLE = 2'b00,
    MCSF_ABORT = 2'b01,
    MCSF_PUSH = 2'b10,
    MCSF_DONE = 2'b11
  } mcsf_state_e;
endpackage

// ---- design/mcsf_unit.sv ----
// machine check unit: abort, frame push, acknowledge and double check halt
//
// Summary of operation
// [RQ1] count word holds frame bytes minus three longwords
// [RQ2] handler finds PC and PROCESSOR_STATUS_LONGWORD via count
// [RQ3] trap level goes to word 1 top
// [RQ4] reason code in word 1 bits 23:16
// [RQ5] processor number in word 1 low byte
// [RQ6] interrupt state word at offset 8
// [RQ7] microcode saved PC at offset 12
// [RQ8] address latch at offset 16
// [RQ9] shifter latch at offset 20
// [RQ10] register index in word 6 top
// [RQ11] current mode copied to bits 25:24
// [RQ12] low opcode byte in bits 23:16
// [RQ13] restart bit set only when state untouched
// [RQ14] fault PC at offset 28
// [RQ15] fault status longword at offset 32
// [RQ16] ack write of zero clears in-progress
// [RQ17] undefined frame bits carry zero here
// [RQ18] abort instruction, unwind, then push frame
// [RQ19] internal or hardware errors raise checks
// [RQ20] reason codes 01 to 06 in order
// [RQ21] nested check halts with code 12
// [RQ22] frame written as consecutive longwords
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module mcsf_unit
  import mcsf_pkg::*;
(
  input wire logic CLOCK, // core clock, 10 MHz
  input wire logic SRST, // synchronous reset, high
  input wire logic [MCSF_NSRC-1:0] ERR_EVENT, // check sources, one-cycle pulses
  input wire mcsf_state_s CORE_STATE, // processor state at the fault
  input wire logic STACK_READY, // stack write accepted this cycle
  input wire logic UNWIND_DONE, // core finished unwinding
  input wire logic [7:0] WB_ADR_I, // wishbone address
  input wire logic [31:0] WB_DAT_I, // wishbone write data
  input wire logic [3:0] WB_SEL_I, // wishbone byte selects
  input wire logic WB_WE_I, // wishbone write enable
  input wire logic WB_CYC_I, // wishbone cycle
  input wire logic WB_STB_I, // wishbone strobe
  output logic [31:0] WB_DAT_O, // wishbone read data
  output logic WB_ACK_O, // wishbone acknowledge
  output logic ABORT_REQ, // abort and unwind current instruction
  output mcsf_wr_s STACK_WR, // frame longword write
  output logic [31:0] NEW_SP, // stack pointer after the push
  output logic FRAME_DONE, // frame pushed, enter handler, pulse
  output logic MCHECK_BUSY, // machine check in progress flag
  output logic HALT_REQ, // console halt request, pulse
  output logic [7:0] HALT_CODE // halt code with the request
);
  mcsf_state_e state; // sequencer state
  mcsf_state_s snap; // captured state
  logic [7:0] code; // latched reason code
  logic [3:0] idx; // longword being pushed
  logic [31:0] sp; // stack pointer register
  logic [31:0] base; // frame base
  logic [31:0] word; // current frame longword
  logic [7:0] next_code; // encoded reason
  logic any_err; // some source fired
  logic wb_hit; // bus request this cycle
  logic ack_wr; // acknowledge register write of zero

  // lowest numbered source wins when several fire at once
  // [RQ20] ordered reason codes
  always_comb begin
    next_code = 8'h00;
    for (int i = MCSF_NSRC - 1; i >= 0; i--) begin
      if (ERR_EVENT[i]) begin
        next_code = 8'(i + 1);
      end
    end
  end
  assign any_err = |ERR_EVENT;

  assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // [RQ16] acknowledge needs a written zero
  assign ack_wr = wb_hit && WB_WE_I && (WB_ADR_I == MCSF_ADR_ACK) && (WB_DAT_I == 32'h0000_0000);

  // frame word mux; unlisted bits held zero
  // [RQ17] undefined bits zeroed
  always_comb begin
    word = 32'h0000_0000;
    case (idx)
      // [RQ1] byte count word
      MCSF_IDX_COUNT: word = MCSF_BYTE_COUNT;
      MCSF_IDX_CODE: begin
        // [RQ3] trap level field
        word[MCSF_TRAP_LSB +: 3] = snap.trap_level;
        // [RQ4] reason code field
        word[MCSF_CODE_LSB +: 8] = code;
        // [RQ5] processor number field
        word[7:0] = snap.proc_number;
      end
      // [RQ6] interrupt state word
      MCSF_IDX_INTSTATE: word = snap.int_state;
      // [RQ7] saved pc word
      MCSF_IDX_MICROCODE_SAVED_PC: word = snap.saved_pc;
      // [RQ8] address latch word
      MCSF_IDX_ADDRLATCH: word = snap.addr_latch;
      // [RQ9] shifter latch word
      MCSF_IDX_SHIFTLATCH: word = snap.shift_latch;
      MCSF_IDX_OPWORD: begin
        // [RQ10] register index field
        word[MCSF_RIDX_LSB +: 4] = snap.reg_index;
        // [RQ11] current mode field
        word[MCSF_MODE_LSB +: 2] = snap.processor_status_longword[MCSF_PSL_MODE_LSB +: 2];
        // [RQ12] opcode low byte, no prefix
        word[MCSF_OPC_LSB +: 8] = snap.opcode;
        // [RQ13] restart clean bit
        word[MCSF_RESTART_BIT] = snap.clean;
      end
      // [RQ14] fault pc word
      MCSF_IDX_PC: word = snap.pc;
      // [RQ15] fault status word
      MCSF_IDX_PSL: word = snap.processor_status_longword;
      default: word = 32'h0000_0000;
    endcase
  end

  // main sequencer: abort, unwind, push, done
  // [RQ18] abort then push
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      state <= MCSF_IDLE;
      snap <= '0;
      code <= 8'h00;
      idx <= 4'h0;
      base <= 32'h0000_0000;
    end else begin
      case (state)
        MCSF_IDLE: begin
          // [RQ19] any error raises a check when none is in progress
          if (any_err && !MCHECK_BUSY) begin
            state <= MCSF_ABORT;
            snap <= CORE_STATE;
            code <= next_code;
            idx <= MCSF_IDX_COUNT;
            base <= sp - MCSF_FRAME_BYTES;
          end
        end
        MCSF_ABORT: begin
          // wait until the core has unwound to a fault
          if (UNWIND_DONE) begin
            state <= MCSF_PUSH;
          end
        end
        MCSF_PUSH: begin
          // [RQ22] consecutive longwords
          if (STACK_WR.valid && STACK_READY) begin
            if (idx == MCSF_IDX_PSL) begin
              state <= MCSF_DONE;
            end else begin
              idx <= idx + 4'h1;
            end
          end
        end
        MCSF_DONE: state <= MCSF_IDLE;
        default: state <= MCSF_IDLE;
      endcase
    end
  end

  // stack write port, registered
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      STACK_WR <= '0;
    end else if (state == MCSF_PUSH && !(STACK_WR.valid && STACK_READY && idx == MCSF_IDX_PSL)) begin
      STACK_WR.valid <= 1'b1;
      // advance one word on each accepted write
      if (STACK_WR.valid && STACK_READY) begin
        STACK_WR.addr <= base + {26'h0, idx + 4'h1, 2'b00};
        STACK_WR.data <= word_next(idx + 4'h1);
      end else begin
        STACK_WR.addr <= base + {26'h0, idx, 2'b00};
        STACK_WR.data <= word;
      end
    end else begin
      STACK_WR <= '0;
    end
  end

  // word for the following index, same layout as the mux
  function automatic logic [31:0] word_next(input logic [3:0] i);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (i)
      MCSF_IDX_CODE: begin
        w[MCSF_TRAP_LSB +: 3] = snap.trap_level;
        w[MCSF_CODE_LSB +: 8] = code;
        w[7:0] = snap.proc_number;
      end
      MCSF_IDX_INTSTATE: w = snap.int_state;
      MCSF_IDX_MICROCODE_SAVED_PC: w = snap.saved_pc;
      MCSF_IDX_ADDRLATCH: w = snap.addr_latch;
      MCSF_IDX_SHIFTLATCH: w = snap.shift_latch;
      MCSF_IDX_OPWORD: begin
        w[MCSF_RIDX_LSB +: 4] = snap.reg_index;
        w[MCSF_MODE_LSB +: 2] = snap.processor_status_longword[MCSF_PSL_MODE_LSB +: 2];
        w[MCSF_OPC_LSB +: 8] = snap.opcode;
        w[MCSF_RESTART_BIT] = snap.clean;
      end
      MCSF_IDX_PC: w = snap.pc;
      MCSF_IDX_PSL: w = snap.processor_status_longword;
      default: w = MCSF_BYTE_COUNT;
    endcase
    return w;
  endfunction

  // done pulse and new stack pointer
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      FRAME_DONE <= 1'b0;
      NEW_SP <= MCSF_SP_RESET;
    end else begin
      FRAME_DONE <= (state == MCSF_PUSH) && STACK_WR.valid && STACK_READY && (idx == MCSF_IDX_PSL);
      if (state == MCSF_ABORT) begin
        NEW_SP <= base;
      end
    end
  end

  // in-progress flag; a new check wins over an ack in the same cycle
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      MCHECK_BUSY <= 1'b0;
    end else if (state == MCSF_IDLE && any_err && !MCHECK_BUSY) begin
      MCHECK_BUSY <= 1'b1;
    // [RQ16] clear on acknowledge
    end else if (ack_wr) begin
      MCHECK_BUSY <= 1'b0;
    end
  end

  // nested check: no frame, console halt instead
  // [RQ21] double check halt
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      HALT_REQ <= 1'b0;
      HALT_CODE <= 8'h00;
    end else begin
      HALT_REQ <= any_err && MCHECK_BUSY;
      if (any_err && MCHECK_BUSY) begin
        HALT_CODE <= MCSF_HALT_DOUBLE;
      end
    end
  end

  // abort held from capture until unwinding finishes
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ABORT_REQ <= 1'b0;
    end else begin
      ABORT_REQ <= (state == MCSF_IDLE && any_err && !MCHECK_BUSY) ||
                   (state == MCSF_ABORT && !UNWIND_DONE);
    end
  end

  // stack pointer register, software writable so the frame lands in known memory
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sp <= MCSF_SP_RESET;
    end else if (wb_hit && WB_WE_I && WB_ADR_I == MCSF_ADR_SP) begin
      sp <= WB_DAT_I;
    end else if (state == MCSF_DONE) begin
      sp <= base;
    end
  end

  // wishbone slave: one wait-free answer, ack one cycle after strobe
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_hit;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_hit && !WB_WE_I) begin
        if (WB_ADR_I == MCSF_ADR_STATUS) begin
          WB_DAT_O <= {28'h0, 2'(state), HALT_REQ, MCHECK_BUSY};
        end else if (WB_ADR_I == MCSF_ADR_SP) begin
          WB_DAT_O <= sp;
        end else if (WB_ADR_I == MCSF_ADR_LASTCODE) begin
          WB_DAT_O <= {24'h0, code};
        end else begin
          WB_DAT_O <= 32'h0000_0000;
        end
      end
    end
  end

  // checks
  a_busy_set: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == MCSF_IDLE && any_err && !MCHECK_BUSY) |=> MCHECK_BUSY) // [RQ16]
    else $error("busy flag not set on check");
  a_ack_clear: assert property (@(posedge CLOCK) disable iff (SRST)
    (ack_wr && !any_err) |=> !MCHECK_BUSY) // [RQ16]
    else $error("ack did not clear busy");
  a_nested_halt: assert property (@(posedge CLOCK) disable iff (SRST)
    (any_err && MCHECK_BUSY) |=> HALT_REQ && HALT_CODE == MCSF_HALT_DOUBLE) // [RQ21]
    else $error("nested check did not halt");
  a_count_word: assert property (@(posedge CLOCK) disable iff (SRST)
    (STACK_WR.valid && STACK_WR.addr == base) |-> STACK_WR.data == MCSF_BYTE_COUNT) // [RQ1]
    else $error("bad count word");
  a_psl_word: assert property (@(posedge CLOCK) disable iff (SRST)
    (STACK_WR.valid && STACK_WR.addr == base + 32'h20) |-> STACK_WR.data == snap.processor_status_longword) // [RQ15]
    else $error("bad status word");
  a_pc_word: assert property (@(posedge CLOCK) disable iff (SRST)
    (STACK_WR.valid && STACK_WR.addr == base + 32'h1C) |-> STACK_WR.data == snap.pc) // [RQ14]
    else $error("bad pc word");
  a_code_word: assert property (@(posedge CLOCK) disable iff (SRST)
    (STACK_WR.valid && STACK_WR.addr == base + 32'h4) |-> STACK_WR.data[23:16] == code) // [RQ4]
    else $error("bad reason code");
  a_no_push_abort: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == MCSF_ABORT) |-> !STACK_WR.valid) // [RQ18]
    else $error("push before unwind");
  a_bus_ack: assert property (@(posedge CLOCK) disable iff (SRST)
    (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O) // [RQ16]
    else $error("bus ack timing");

  // field checks on the pushed words, against the captured snapshot
  // [RQ3] trap level field
  a_trap_field: assert property (@(posedge CLOCK) disable iff (SRST)
    (STACK_WR.valid && STACK_WR.addr == base + 32'h4) |-> STACK_WR.data[31:29] == snap.trap_level) // [RQ3]
    else $error("bad trap level field");
  // [RQ5] processor number field
  a_cpu_field: assert property (@(posedge CLOCK) disable iff (SRST)
    (STACK_WR.valid && STACK_WR.addr == base + 32'h4) |-> STACK_WR.data[7:0] == snap.proc_number) // [RQ5]
    else $error("bad processor number field");
  // [RQ11] current mode field
  a_mode_field: assert property (@(posedge CLOCK) disable iff (SRST)
    (STACK_WR.valid && STACK_WR.addr == base + 32'h18) |-> STACK_WR.data[25:24] == snap.processor_status_longword[25:24]) // [RQ11]
    else $error("bad mode field");
  // [RQ12] opcode low byte
  a_opcode_field: assert property (@(posedge CLOCK) disable iff (SRST)
    (STACK_WR.valid && STACK_WR.addr == base + 32'h18) |-> STACK_WR.data[23:16] == snap.opcode) // [RQ12]
    else $error("bad opcode field");
  // [RQ13] restart clean bit
  a_restart_bit: assert property (@(posedge CLOCK) disable iff (SRST)
    (STACK_WR.valid && STACK_WR.addr == base + 32'h18) |-> STACK_WR.data[7] == snap.clean) // [RQ13]
    else $error("bad restart bit");
  // [RQ6] interrupt state word
  a_intstate_word: assert property (@(posedge CLOCK) disable iff (SRST)
    (STACK_WR.valid && STACK_WR.addr == base + 32'h8) |-> STACK_WR.data == snap.int_state) // [RQ6]
    else $error("bad interrupt state word");
  // [RQ22] write held until the stack takes it
  a_wr_held: assert property (@(posedge CLOCK) disable iff (SRST)
    (STACK_WR.valid && !STACK_READY) |=> STACK_WR.valid && $stable(STACK_WR.addr) &&
    $stable(STACK_WR.data)) // [RQ22]
    else $error("stack write dropped before accept");
  // [RQ18] abort stands while unwinding
  a_abort_hold: assert property (@(posedge CLOCK) disable iff (SRST)
    (state == MCSF_ABORT && !UNWIND_DONE) |=> ABORT_REQ) // [RQ18]
    else $error("abort request dropped early");
  // [RQ21] nested check starts no frame
  a_nested_noframe: assert property (@(posedge CLOCK) disable iff (SRST)
    (any_err && MCHECK_BUSY && state == MCSF_IDLE) |=> state == MCSF_IDLE) // [RQ21]
    else $error("nested check started a frame");
  // [RQ22] done is a single pulse
  a_done_pulse: assert property (@(posedge CLOCK) disable iff (SRST)
    FRAME_DONE |=> !FRAME_DONE) // [RQ22]
    else $error("frame done longer than one cycle");
  // [RQ22] new stack pointer is the frame base
  a_new_sp: assert property (@(posedge CLOCK) disable iff (SRST)
    FRAME_DONE |-> NEW_SP == base) // [RQ22]
    else $error("new stack pointer not frame base");
  c_frame: cover property (@(posedge CLOCK) FRAME_DONE);
  c_slow_push: cover property (@(posedge CLOCK) STACK_WR.valid && !STACK_READY ##1 !STACK_READY);
  c_nested: cover property (@(posedge CLOCK) HALT_REQ);
  c_ack: cover property (@(posedge CLOCK) ack_wr && MCHECK_BUSY);
endmodule
`default_nettype wire

// ---- test/mcsf_stack_model.sv ----
// far side model: stack memory and core unwind, prompt or slow
`timescale 1ns/10ps
`default_nettype none
module mcsf_stack_model
  import mcsf_pkg::*;
(
  input wire logic CLOCK, // core clock
  input wire logic SRST, // sync reset, high
  input wire logic ABORT_REQ, // unwind request from the unit
  input wire mcsf_wr_s STACK_WR, // frame longword write
  input wire logic SLOW, // stall the answers
  output logic STACK_READY, // write accepted this cycle
  output logic UNWIND_DONE // unwind finished, pulse
);
  logic [31:0] mem [64]; // stack bytes 255:0 by longword
  logic [2:0] cnt; // free running stall pacer
  int writes; // accepted longwords
  // pacing and handshakes; ready only ever follows a held request
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cnt <= 3'h0;
      STACK_READY <= 1'b0;
      UNWIND_DONE <= 1'b0;
      writes <= 0;
    end else begin
      cnt <= cnt + 3'h1;
      STACK_READY <= STACK_WR.valid && !STACK_READY && (!SLOW || cnt[0]);
      UNWIND_DONE <= ABORT_REQ && !UNWIND_DONE && (!SLOW || cnt == 3'h7);
      // store only at the accepting edge
      if (STACK_WR.valid && STACK_READY) begin
        mem[STACK_WR.addr[7:2]] <= STACK_WR.data;
        writes <= writes + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// bench: frame pushes for every code, nested check halt, register access
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mcsf_pkg::*;
  `define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
  logic CLOCK, SRST, slow, we, cyc, stb, ack, abort, ready, unwind, fdone, busy, halt;
  logic [MCSF_NSRC-1:0] err; // check sources
  mcsf_state_s st; // core state shown at the fault
  mcsf_wr_s wr; // stack write
  logic [7:0] adr, hcode;
  logic [31:0] wdat, rdat, dat_o, nsp, seed;
  logic [3:0] sel;
  int miscompares, checked;
  mcsf_unit mcsf_unit_inst (.CLOCK(CLOCK), .SRST(SRST), .ERR_EVENT(err), .CORE_STATE(st),
    .STACK_READY(ready), .UNWIND_DONE(unwind), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .ABORT_REQ(abort), .STACK_WR(wr), .NEW_SP(nsp), .FRAME_DONE(fdone),
    .MCHECK_BUSY(busy), .HALT_REQ(halt), .HALT_CODE(hcode));
  mcsf_stack_model mcsf_stack_model_inst (.CLOCK(CLOCK), .SRST(SRST), .ABORT_REQ(abort),
    .STACK_WR(wr), .SLOW(slow), .STACK_READY(ready), .UNWIND_DONE(unwind));
  // 100 ns clock
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end
  // xorshift, fixed start keeps runs repeatable
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected longword k of a frame
  function automatic logic [31:0] fword(int k, mcsf_state_s s, logic [7:0] c);
    case (k)
      0: return 32'h00000018;
      1: return {s.trap_level, 5'h00, c, 8'h00, s.proc_number};
      2: return s.int_state;
      3: return s.saved_pc;
      4: return s.addr_latch;
      5: return s.shift_latch;
      6: return {s.reg_index, 2'h0, s.processor_status_longword[25:24], s.opcode, 8'h00, s.clean, 7'h00};
      7: return s.pc;
      default: return s.processor_status_longword;
    endcase
  endfunction
  // undefined frame bits are never compared
  function automatic logic [31:0] fmask(int k);
    return (k == 1) ? 32'hE0FF00FF : (k == 6) ? 32'hF3FF0080 : 32'hFFFFFFFF;
  endfunction
  task automatic tally_and_finish();
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one classic wishbone cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge CLOCK);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin @(posedge CLOCK); n++; end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin miscompares++; tally_and_finish(); end
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  initial begin
    repeat (100000) @(posedge CLOCK);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    logic [215:0] r;
    logic [31:0] sp, base, t, cnt;
    logic [5:0] bits;
    int c, n, w0, ab, bad, hs;
    seed = 32'd66983; SRST = 1'b1; err = '0; st = '0; slow = 1'b0; sel = 4'hF;
    adr = 8'h00; wdat = 32'h0; we = 1'b0; cyc = 1'b0; stb = 1'b0;
    miscompares = 0; checked = 0;
    repeat (8) @(posedge CLOCK);
    SRST <= 1'b0;
    @(posedge CLOCK);
    `CHK(nsp, 32'h00001000)
    bus(1'b0, MCSF_ADR_SP, 32'h0, rdat);
    `CHK(rdat, 32'h00001000)
    // unmapped place reads zero
    bus(1'b0, 8'hF0, 32'h0, rdat);
    `CHK(rdat, 32'h00000000)
    for (int i = 0; i < 12; i++) begin
      c = i % 6;
      // second pass adds higher sources, the lowest must still win
      bits = (6'h01 << c) | ({6{i >= 6}} & (6'h3E << c));
      slow <= i[0];
      t = rnd();
      sp = 32'h00002000 + {22'h0, t[9:2], 2'b00};
      bus(1'b1, MCSF_ADR_SP, sp, rdat);
      for (int j = 0; j < 27; j++) begin t = rnd(); r[j*8+:8] = t[7:0]; end
      base = sp - 32'h00000024;
      w0 = mcsf_stack_model_inst.writes;
      @(posedge CLOCK);
      st <= r; err <= bits;
      @(posedge CLOCK);
      err <= '0;
      n = 0; ab = 0; bad = 0;
      // abort first, no frame write during it
      do begin
        @(posedge CLOCK); n++;
        if (abort === 1'b1) ab = 1;
        if (abort === 1'b1 && wr.valid === 1'b1) bad = 1;
      end while (fdone !== 1'b1 && n < 300);
      if (fdone !== 1'b1) begin miscompares++; tally_and_finish(); end
      `CHK(ab, 1)
      `CHK(bad, 0)
      `CHK(mcsf_stack_model_inst.writes, w0 + 9)
      for (int k = 0; k < 9; k++) begin
        t = base + 32'(4 * k);
        `CHK(mcsf_stack_model_inst.mem[t[7:2]] & fmask(k), fword(k, r, 8'(c + 1)) & fmask(k))
      end
      // fault PC and PROCESSOR_STATUS_LONGWORD found through the count
      cnt = mcsf_stack_model_inst.mem[base[7:2]];
      t = base + 32'h4 + cnt;
      `CHK(mcsf_stack_model_inst.mem[t[7:2]], r[63:32])
      t = t + 32'h4;
      `CHK(mcsf_stack_model_inst.mem[t[7:2]], r[31:0])
      `CHK(nsp, base)
      `CHK(busy, 1'b1)
      bus(1'b0, MCSF_ADR_LASTCODE, 32'h0, rdat);
      `CHK(rdat[7:0], 8'(c + 1))
      // nested check while in progress halts without a frame
      if (i % 3 == 0) begin
        @(posedge CLOCK);
        err <= bits;
        @(posedge CLOCK);
        err <= '0;
        hs = 0;
        repeat (4) begin
          @(posedge CLOCK);
          if (halt === 1'b1 && hcode === 8'h12) hs = 1;
        end
        `CHK(hs, 1)
        `CHK(mcsf_stack_model_inst.writes, w0 + 9)
      end
      bus(1'b1, MCSF_ADR_ACK, 32'h0, rdat);
      repeat (2) @(posedge CLOCK);
      `CHK(busy, 1'b0)
      bus(1'b0, MCSF_ADR_STATUS, 32'h0, rdat);
      `CHK(rdat[0], 1'b0)
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
